/* hdl/ebm_pkg.sv */
// shared constants, codes and helpers for the external bus master
package ebm_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int OPND_W = 32;
  localparam int REM_W  = 3;
  localparam int MON_W  = 7;

  // ------------------------------------------------------------
  // bus cycle states, gray along idle-addr-wait-term-step
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    EBM_IDLE = 3'h0,
    EBM_ADDR = 3'h1,
    EBM_WAIT = 3'h3,
    EBM_TERM = 3'h2,
    EBM_STEP = 3'h6
  } ebm_state_e;

  // ------------------------------------------------------------
  // size codes, also used for the requested operand size
  // ------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE  = 2'h1;
  localparam logic [1:0] SZ_WORD  = 2'h2;
  localparam logic [1:0] SZ_THREE = 2'h3;
  localparam logic [1:0] SZ_LONG  = 2'h0;

  localparam logic [REM_W-1:0] REM_NONE  = 3'h0;
  localparam logic [REM_W-1:0] REM_ONE   = 3'h1;
  localparam logic [REM_W-1:0] REM_TWO   = 3'h2;
  localparam logic [REM_W-1:0] REM_THREE = 3'h3;
  localparam logic [REM_W-1:0] REM_FOUR  = 3'h4;

  // ------------------------------------------------------------
  // address space codes
  // ------------------------------------------------------------
  localparam logic [2:0] SPC_USER_DATA = 3'h1;
  localparam logic [2:0] SPC_USER_PROG = 3'h2;
  localparam logic [2:0] SPC_SUPV_DATA = 3'h5;
  localparam logic [2:0] SPC_SUPV_PROG = 3'h6;
  localparam logic [2:0] SPC_CPU       = 3'h7;

  // ------------------------------------------------------------
  // acknowledge pair levels, bit 1 is the upper line, low active
  // ------------------------------------------------------------
  localparam logic [1:0] ACK_WAIT   = 2'h3;
  localparam logic [1:0] ACK_PORT8  = 2'h2;
  localparam logic [1:0] ACK_PORT16 = 2'h1;

  // ------------------------------------------------------------
  // bus monitor, code 0 gives the longest period
  // ------------------------------------------------------------
  localparam logic [MON_W-1:0] MON_BASE_CLOCKS = 7'h40;
  localparam logic [MON_W-1:0] MON_ONE         = 7'h01;

  localparam logic [ADDR_W-1:0] ADDR_ONE = 24'h000001;
  localparam logic [ADDR_W-1:0] ADDR_TWO = 24'h000002;

  // remaining byte count to the size code driven on the pins
  function automatic logic [1:0] size_code(input logic [REM_W-1:0] rem);
    case (rem)
      REM_ONE:   size_code = SZ_BYTE;
      REM_TWO:   size_code = SZ_WORD;
      REM_THREE: size_code = SZ_THREE;
      default:   size_code = SZ_LONG;
    endcase
  endfunction : size_code

  // requested operand size to its byte count
  function automatic logic [REM_W-1:0] size_bytes(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: size_bytes = REM_ONE;
      SZ_WORD: size_bytes = REM_TWO;
      default: size_bytes = REM_FOUR;
    endcase
  endfunction : size_bytes

endpackage : ebm_pkg

/* hdl/ebm_bus_monitor.sv */
// response-time watchdog that flags a cycle left without termination
`timescale 1ns/1ps

module ebm_bus_monitor #(
  parameter int CNT_W = ebm_pkg::MON_W
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // control
  input  wire logic             run,
  input  wire logic [1:0]       period_sel,
  // result
  output logic                  timeout
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;

  // ------------------------------------------------------------
  // period select
  // ------------------------------------------------------------
  assign limit = CNT_W'(ebm_pkg::MON_BASE_CLOCKS >> period_sel);

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // run stays high across all byte cycles of one operand, so an
  // 8-bit port word needs a period of at least two byte accesses
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q   <= '0;
      timeout <= 1'b0;
    end else if (!run) begin
      cnt_q   <= '0;
      timeout <= 1'b0;
    end else if (cnt_q == limit - ebm_pkg::MON_ONE) begin
      timeout <= 1'b1;
    end else begin
      cnt_q <= cnt_q + ebm_pkg::MON_ONE;
    end
  end

endmodule : ebm_bus_monitor

/* hdl/ebm_master.sv */
// asynchronous external bus master with dynamic port sizing
//
// How it works
// - 24-bit address, 16-bit bidirectional data bus
// - drive operand byte address, hold during strobe
// - location strobe half clock after start
// - read data latched on last falling edge
// - writes drive all sixteen data lines
// - write data half clock after location strobe
// - read transfer strobe together with location strobe
// - write transfer strobe one clock after location
// - direction changes only at cycle start
// - remaining size code during the strobe
// - three-bit space code during the strobe
// - space from supervisor state and access type
// - chip-select acknowledges accepted as well
// - bus fault ends unanswered or faulty cycle
// - internal monitor raises fault, can be disabled
// - byte, word, long to 8/16-bit ports
// - ack pair decode: wait, 8-bit, 16-bit
// - every cycle assumes 16-bit, moves maximum
// - monitor period 64, 32, 16, 8 clocks
`timescale 1ns/1ps

module ebm_master #(
  parameter int ADDR_W = ebm_pkg::ADDR_W,
  parameter int DATA_W = ebm_pkg::DATA_W,
  parameter int OPND_W = ebm_pkg::OPND_W
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // processor request
  input  wire logic              cpu_req_valid,
  output logic                   cpu_req_ready,
  input  wire logic              cpu_req_write,
  input  wire logic [1:0]        cpu_req_size,
  input  wire logic [ADDR_W-1:0] cpu_req_addr,
  input  wire logic [OPND_W-1:0] cpu_req_wdata,
  input  wire logic              cpu_req_supervisor,
  input  wire logic              cpu_req_program,
  input  wire logic              cpu_req_cpu_space,
  // processor answer
  output logic                   cpu_done,
  output logic [OPND_W-1:0]      cpu_rdata,
  output logic                   cpu_fault,
  output logic                   cpu_autovec,
  // monitor configuration
  input  wire logic [1:0]        monitor_period_sel,
  input  wire logic              monitor_external_en,
  // chip-select terminations
  input  wire logic [1:0]        cs_port_width_ack_n,
  input  wire logic              cs_auto_vector_ack_n,
  // external bus pins
  output logic [ADDR_W-1:0]      bus_addr,
  input  wire logic [DATA_W-1:0] bus_data_in,
  output logic [DATA_W-1:0]      bus_data_out,
  output logic                   bus_data_oe,
  output logic                   location_strobe_n,
  output logic                   transfer_strobe_n,
  output logic                   bus_read,
  output logic [1:0]             remaining_size_code,
  output logic [2:0]             space_code,
  input  wire logic [1:0]        port_width_ack_n,
  input  wire logic              bus_fault_in_n,
  input  wire logic              auto_vector_ack_n
);

  localparam int LANE_W = DATA_W / 2;

  ebm_pkg::ebm_state_e state_q;
  ebm_pkg::ebm_state_e state_d;

  logic [ADDR_W-1:0]        addr_q;
  logic [OPND_W-1:0]        wbuf_q;
  logic [OPND_W-1:0]        rbuf_q;
  logic [ebm_pkg::REM_W-1:0] rem_q;
  logic [ebm_pkg::REM_W-1:0] step_n;
  logic [ebm_pkg::REM_W-1:0] rem_left;
  logic                     write_q;
  logic                     port8_q;
  logic                     fault_q;
  logic                     auto_vector_ack_q;
  logic [DATA_W-1:0]        rd_cap_q;
  logic [DATA_W-1:0]        rd_stage_q;
  logic [OPND_W-1:0]        rbuf_d;
  logic [LANE_W-1:0]        rd_byte;
  logic [DATA_W-1:0]        wr_lanes;
  logic [2:0]               req_space;

  logic [3:0]               pin_meta_q;
  logic [3:0]               pin_sync_q;
  logic [1:0]               ack_s;
  logic                     ack8;
  logic                     ack16;
  logic                     auto_vector_ack_hit;
  logic                     fault_hit;
  logic                     mon_timeout;
  logic                     take;
  logic                     terminate;
  logic                     last_cycle;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_q <= 4'hF;
      pin_sync_q <= 4'hF;
    end else begin
      pin_meta_q <= {port_width_ack_n, bus_fault_in_n, auto_vector_ack_n};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ------------------------------------------------------------
  // termination decode
  // ------------------------------------------------------------
  // low-active lines from pins and chip selects are wire-anded
  assign ack_s     = pin_sync_q[3:2] & cs_port_width_ack_n;
  assign ack8      = (ack_s == ebm_pkg::ACK_PORT8);
  assign ack16     = (ack_s == ebm_pkg::ACK_PORT16);
  // autovector only counts in processor control space
  assign auto_vector_ack_hit  = (addr_space_is_cpu(space_code, state_q) == 1'b0) ? 1'b0 :
                     (!pin_sync_q[0] || !cs_auto_vector_ack_n);
  assign fault_hit = !pin_sync_q[1] || mon_timeout;
  // the reserved all-low pair is treated as wait; the monitor ends it
  assign terminate = (state_q == ebm_pkg::EBM_WAIT) && (ack8 || ack16 || auto_vector_ack_hit || fault_hit);
  assign take      = cpu_req_valid && cpu_req_ready;

  function automatic logic addr_space_is_cpu(input logic [2:0] spc, input ebm_pkg::ebm_state_e st);
    addr_space_is_cpu = (spc == ebm_pkg::SPC_CPU) && (st == ebm_pkg::EBM_WAIT);
  endfunction : addr_space_is_cpu

  // ------------------------------------------------------------
  // space code from processor state
  // ------------------------------------------------------------
  always_comb begin
    if (cpu_req_cpu_space) begin
      req_space = ebm_pkg::SPC_CPU;
    end else if (cpu_req_supervisor) begin
      req_space = cpu_req_program ? ebm_pkg::SPC_SUPV_PROG : ebm_pkg::SPC_SUPV_DATA;
    end else begin
      req_space = cpu_req_program ? ebm_pkg::SPC_USER_PROG : ebm_pkg::SPC_USER_DATA;
    end
  end

  // ------------------------------------------------------------
  // sizing arithmetic
  // ------------------------------------------------------------
  // an 8-bit port, an odd address or a last byte moves one byte
  assign step_n     = (port8_q || addr_q[0] || rem_q == ebm_pkg::REM_ONE) ?
                      ebm_pkg::REM_ONE : ebm_pkg::REM_TWO;
  assign rem_left   = rem_q - step_n;
  assign last_cycle = (rem_left == ebm_pkg::REM_NONE) || fault_q || auto_vector_ack_q;

  // lanes: byte on 8-bit port on the upper lane, odd byte on a
  // 16-bit port on the lower lane, aligned word on both
  assign rd_byte = (port8_q || !addr_q[0]) ? rd_stage_q[DATA_W-1:LANE_W] : rd_stage_q[LANE_W-1:0];

  always_comb begin
    if (step_n == ebm_pkg::REM_TWO) begin
      rbuf_d = {rbuf_q[OPND_W-DATA_W-1:0], rd_stage_q};
    end else begin
      rbuf_d = {rbuf_q[OPND_W-LANE_W-1:0], rd_byte};
    end
  end

  // port width is unknown when data is driven, so a lone byte goes on
  // both lanes and a pair of bytes as an aligned word
  always_comb begin
    if (rem_q == ebm_pkg::REM_ONE || addr_q[0]) begin
      wr_lanes = {wbuf_q[OPND_W-1 -: LANE_W], wbuf_q[OPND_W-1 -: LANE_W]};
    end else begin
      wr_lanes = wbuf_q[OPND_W-1 -: DATA_W];
    end
  end

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ebm_pkg::EBM_IDLE: begin
        if (take) begin
          state_d = ebm_pkg::EBM_ADDR;
        end
      end
      ebm_pkg::EBM_ADDR: begin
        state_d = ebm_pkg::EBM_WAIT;
      end
      ebm_pkg::EBM_WAIT: begin
        if (terminate) begin
          state_d = ebm_pkg::EBM_TERM;
        end
      end
      ebm_pkg::EBM_TERM: begin
        state_d = ebm_pkg::EBM_STEP;
      end
      ebm_pkg::EBM_STEP: begin
        // strobes were negated at the falling edge inside term
        state_d = last_cycle ? ebm_pkg::EBM_IDLE : ebm_pkg::EBM_ADDR;
      end
      default: begin
        state_d = ebm_pkg::EBM_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ebm_pkg::EBM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // operand bookkeeping
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addr_q  <= '0;
      wbuf_q  <= '0;
      rem_q   <= ebm_pkg::REM_NONE;
      write_q <= 1'b0;
    end else if (take) begin
      addr_q  <= cpu_req_addr;
      wbuf_q  <= cpu_req_wdata << (OPND_W - LANE_W * int'(ebm_pkg::size_bytes(cpu_req_size)));
      rem_q   <= ebm_pkg::size_bytes(cpu_req_size);
      write_q <= cpu_req_write;
    end else if (state_q == ebm_pkg::EBM_STEP && !last_cycle) begin
      addr_q <= (step_n == ebm_pkg::REM_TWO) ? addr_q + ebm_pkg::ADDR_TWO : addr_q + ebm_pkg::ADDR_ONE;
      wbuf_q <= (step_n == ebm_pkg::REM_TWO) ? wbuf_q << DATA_W : wbuf_q << LANE_W;
      rem_q  <= rem_left;
    end
  end

  // ------------------------------------------------------------
  // termination record
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      port8_q <= 1'b0;
      fault_q <= 1'b0;
      auto_vector_ack_q  <= 1'b0;
    end else if (state_q == ebm_pkg::EBM_ADDR) begin
      port8_q <= 1'b0;
      fault_q <= 1'b0;
      auto_vector_ack_q  <= 1'b0;
    end else if (terminate) begin
      port8_q <= ack8;
      fault_q <= fault_hit;
      auto_vector_ack_q  <= auto_vector_ack_hit && !ack8 && !ack16;
    end
  end

  // ------------------------------------------------------------
  // pin-facing control outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_addr            <= '0;
      remaining_size_code <= ebm_pkg::SZ_LONG;
      space_code          <= ebm_pkg::SPC_USER_DATA;
    end else if (state_q == ebm_pkg::EBM_IDLE && take) begin
      bus_addr            <= cpu_req_addr;
      remaining_size_code <= ebm_pkg::size_code(ebm_pkg::size_bytes(cpu_req_size));
      space_code          <= req_space;
    end else if (state_q == ebm_pkg::EBM_STEP && !last_cycle) begin
      bus_addr            <= (step_n == ebm_pkg::REM_TWO) ? addr_q + ebm_pkg::ADDR_TWO : addr_q + ebm_pkg::ADDR_ONE;
      remaining_size_code <= ebm_pkg::size_code(rem_left);
    end
  end

  // direction only moves when a new operand starts
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_read <= 1'b1;
    end else if (take) begin
      bus_read <= !cpu_req_write;
    end
  end

  // write data goes out on the rising edge after the strobe fell
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_data_out <= '0;
      bus_data_oe  <= 1'b0;
    end else if (state_q == ebm_pkg::EBM_ADDR) begin
      bus_data_out <= wr_lanes;
      bus_data_oe  <= write_q;
    end else if (state_q == ebm_pkg::EBM_TERM) begin
      bus_data_oe  <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // falling-edge strobes and read capture
  // ------------------------------------------------------------
  always_ff @(negedge core_clk or negedge resetn) begin
    if (!resetn) begin
      location_strobe_n <= 1'b1;
    end else begin
      location_strobe_n <= !(state_q == ebm_pkg::EBM_ADDR || state_q == ebm_pkg::EBM_WAIT);
    end
  end

  always_ff @(negedge core_clk or negedge resetn) begin
    if (!resetn) begin
      transfer_strobe_n <= 1'b1;
    end else if (write_q) begin
      transfer_strobe_n <= !(state_q == ebm_pkg::EBM_WAIT);
    end else begin
      transfer_strobe_n <= !(state_q == ebm_pkg::EBM_ADDR || state_q == ebm_pkg::EBM_WAIT);
    end
  end

  // the device holds data until the strobes drop, so the edge that
  // negates them is also the safe sampling point
  always_ff @(negedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_cap_q <= '0;
    end else if (state_q == ebm_pkg::EBM_TERM && !write_q) begin
      rd_cap_q <= bus_data_in;
    end
  end

  // second stage brings the captured word into the rising domain
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_stage_q <= '0;
    end else if (state_q == ebm_pkg::EBM_TERM) begin
      rd_stage_q <= rd_cap_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rbuf_q <= '0;
    end else if (take) begin
      rbuf_q <= '0;
    end else if (state_q == ebm_pkg::EBM_STEP && !write_q) begin
      rbuf_q <= rbuf_d;
    end
  end

  // ------------------------------------------------------------
  // processor handshake
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_req_ready <= 1'b1;
      cpu_done      <= 1'b0;
      cpu_rdata     <= '0;
      cpu_fault     <= 1'b0;
      cpu_autovec   <= 1'b0;
    end else begin
      cpu_done <= 1'b0;
      if (take) begin
        cpu_req_ready <= 1'b0;
      end else if (state_q == ebm_pkg::EBM_STEP && last_cycle) begin
        cpu_req_ready <= 1'b1;
        cpu_done      <= 1'b1;
        cpu_rdata     <= write_q ? '0 : rbuf_d;
        cpu_fault     <= fault_q;
        cpu_autovec   <= auto_vector_ack_q;
      end
    end
  end

  // ------------------------------------------------------------
  // bus monitor
  // ------------------------------------------------------------
  // held across every cycle of one operand; software clears the
  // enable when another master can own the bus
  ebm_bus_monitor #(
    .CNT_W (ebm_pkg::MON_W)
  ) u_monitor (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .run        (monitor_external_en && !cpu_req_ready),
    .period_sel (monitor_period_sel),
    .timeout    (mon_timeout)
  );

endmodule : ebm_master

/* bench/ebm_master_assertions.sv */
// concurrent checks on the external bus master ports
`timescale 1ns/1ps

module ebm_master_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // processor request
  input wire logic        cpu_req_valid,
  input wire logic        cpu_req_ready,
  input wire logic        cpu_req_write,
  input wire logic [1:0]  cpu_req_size,
  input wire logic [23:0] cpu_req_addr,
  input wire logic [31:0] cpu_req_wdata,
  input wire logic        cpu_req_supervisor,
  input wire logic        cpu_req_program,
  input wire logic        cpu_req_cpu_space,
  // external bus
  input wire logic [23:0] bus_addr,
  input wire logic [15:0] bus_data_out,
  input wire logic        bus_data_oe,
  input wire logic        location_strobe_n,
  input wire logic        transfer_strobe_n,
  input wire logic        bus_read,
  input wire logic [1:0]  remaining_size_code,
  input wire logic [2:0]  space_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_take;
    cpu_req_valid && cpu_req_ready;
  endsequence
  sequence s_wr_strobe;
    transfer_strobe_n ##1 !transfer_strobe_n;
  endsequence
  sequence s_wr_data;
    !bus_data_oe ##1 bus_data_oe;
  endsequence

  chk_location_strobe_late: assert property (s_take |=> !location_strobe_n)
    else $error("location strobe not low after take");
  chk_read_strobe_pair: assert property (s_take ##0 !cpu_req_write |=> !transfer_strobe_n)
    else $error("read transfer strobe late");
  chk_write_strobe_delay: assert property (s_take ##0 cpu_req_write |=> s_wr_strobe)
    else $error("write transfer strobe timing");
  chk_write_data_drive: assert property (s_take ##0 cpu_req_write |=> s_wr_data)
    else $error("write data enable timing");
  chk_write_word_value: assert property (s_take ##0 cpu_req_write && cpu_req_size == 2'h2 |=>
    ##1 bus_data_out == 16'($past(cpu_req_wdata, 2)))
    else $error("write word value");
  chk_start_address: assert property (s_take |=> bus_addr == $past(cpu_req_addr))
    else $error("start address");
  chk_start_size_code: assert property (s_take |=> remaining_size_code ==
    ($past(cpu_req_size) == 2'h3 ? 2'h0 : $past(cpu_req_size)))
    else $error("start size code");
  chk_space_code_map: assert property (s_take |=> space_code == ($past(cpu_req_cpu_space) ? 3'h7 :
    {$past(cpu_req_supervisor), $past(cpu_req_program), !$past(cpu_req_program)}))
    else $error("space code");
  chk_control_hold_strobe: assert property (!location_strobe_n && !$past(location_strobe_n) |->
    $stable({bus_addr, bus_read, remaining_size_code, space_code}))
    else $error("control changed under strobe");
  chk_direction_at_take: assert property ($changed(bus_read) |-> $past(cpu_req_valid) && $past(cpu_req_ready))
    else $error("direction changed outside start");
  chk_strobes_gap_both: assert property ($rose(location_strobe_n) |-> transfer_strobe_n ##1 location_strobe_n)
    else $error("strobes not both negated");
endmodule : ebm_master_checker

bind ebm_master ebm_master_checker u_chk (.*);

/* bench/ebm_mem_model.sv */
// behavioural memory on the asynchronous bus, 8- or 16-bit port
`timescale 1ns/1ps

module ebm_mem_model (
  // bus from the master
  input  wire logic        core_clk,
  input  wire logic [23:0] bus_addr,
  input  wire logic [15:0] bus_data_out,
  input  wire logic        location_strobe_n,
  input  wire logic        transfer_strobe_n,
  input  wire logic        bus_read,
  input  wire logic [1:0]  remaining_size_code,
  // answers
  output logic [15:0]      bus_data_in,
  output logic [1:0]       port_width_ack_n,
  output logic             bus_fault_in_n,
  // test control: mode 0 normal, 1 silent, 2 fault with ack
  input  wire logic        wide,
  input  wire logic [1:0]  mode,
  input  wire logic [3:0]  delay
);
  logic [7:0] mem [256];
  logic [3:0] waits;
  logic [1:0] ack_q;
  logic       flt_q;
  logic [7:0] a;

  assign a = bus_addr[7:0];
  // answers drop as soon as the strobe goes, like a real decoder
  assign port_width_ack_n = ack_q | {2{location_strobe_n}};
  assign bus_fault_in_n = flt_q | location_strobe_n;

  always @(posedge core_clk) begin
    if (location_strobe_n) begin
      waits <= 4'h0;
      ack_q <= 2'h3;
      flt_q <= 1'b1;
      // released lines must not look like held data
      bus_data_in <= ~bus_data_in;
    end else begin
      waits <= waits + 4'h1;
      bus_data_in <= wide ? {mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}]} : {mem[a], ~mem[a]};
      if (!transfer_strobe_n && waits >= delay && mode != 2'h1 && ack_q == 2'h3) begin
        ack_q <= wide ? 2'h1 : 2'h2;
        flt_q <= mode != 2'h2;
        if (!bus_read && !wide) mem[a] <= bus_data_out[15:8];
        if (!bus_read && wide && remaining_size_code == 2'h1) mem[a] <= a[0] ? bus_data_out[7:0] : bus_data_out[15:8];
        if (!bus_read && wide && remaining_size_code != 2'h1) begin
          mem[{a[7:1], 1'b0}] <= bus_data_out[15:8];
          mem[{a[7:1], 1'b1}] <= bus_data_out[7:0];
        end
      end
    end
  end
endmodule : ebm_mem_model

/* bench/test_async_external_bus_master.sv */
// self-checking bench for the external bus master
`timescale 1ns/1ps

module test_async_external_bus_master;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        vld = 1'b0;
  logic        wr = 1'b0;
  logic [1:0]  sz = 2'h1;
  logic [23:0] ad = 24'h000000;
  logic [31:0] wd = 32'h00000000;
  logic [2:0]  k = 3'h0;
  logic [1:0]  mon_sel = 2'h0;
  logic        mon_en = 1'b0;
  logic        wide = 1'b1;
  logic [1:0]  mode = 2'h0;
  logic [3:0]  dly = 4'h2;
  logic        cs_en = 1'b0, av_en = 1'b0;
  logic        rdy, done, fault, as_n, ds_n, rd, pf_n, auto_vector_ack;
  logic [31:0] rdata;
  logic [23:0] baddr;
  logic [15:0] din, dout;
  logic [1:0]  rsz, ack_n, cs_ack_n;
  logic [31:0] seed = 32'h00008304;
  logic [33:0] exp_q[$];
  logic [33:0] e_m;
  int          num_errors = 0;
  int          tests_run = 0;

  always #50 clk = ~clk;
  assign cs_ack_n = (cs_en && !as_n) ? (wide ? 2'h1 : 2'h2) : 2'h3;

  ebm_master u_dut (
    .core_clk(clk), .resetn(rst_n), .cpu_req_valid(vld), .cpu_req_ready(rdy),
    .cpu_req_write(wr), .cpu_req_size(sz), .cpu_req_addr(ad), .cpu_req_wdata(wd),
    .cpu_req_supervisor(k[0]), .cpu_req_program(k[1]), .cpu_req_cpu_space(&k),
    .cpu_done(done), .cpu_rdata(rdata), .cpu_fault(fault), .cpu_autovec(auto_vector_ack),
    .monitor_period_sel(mon_sel), .monitor_external_en(mon_en),
    .cs_port_width_ack_n(cs_ack_n), .cs_auto_vector_ack_n(!(av_en && !as_n)),
    .bus_addr(baddr), .bus_data_in(din), .bus_data_out(dout), .bus_data_oe(),
    .location_strobe_n(as_n), .transfer_strobe_n(ds_n), .bus_read(rd),
    .remaining_size_code(rsz), .space_code(), .port_width_ack_n(ack_n),
    .bus_fault_in_n(pf_n), .auto_vector_ack_n(1'b1));

  ebm_mem_model u_mem (
    .core_clk(clk), .bus_addr(baddr), .bus_data_out(dout), .location_strobe_n(as_n),
    .transfer_strobe_n(ds_n), .bus_read(rd), .remaining_size_code(rsz), .bus_data_in(din),
    .port_width_ack_n(ack_n), .bus_fault_in_n(pf_n), .wide(wide), .mode(mode), .delay(dly));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // e is {check fault only, fault, read data}; valid left high for back-to-back takes
  task automatic op(input logic w, input logic [1:0] s, input logic [23:0] a,
                    input logic [31:0] d, input logic [33:0] e);
    int n = 0;
    logic [31:0] r;
    r = xs();
    {wr, sz, ad, wd, vld} = {w, s, a, d, 1'b1};
    k = k + 3'h1;
    dly = 4'h2 + {1'b0, r[2:0]};
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 500);
    exp_q.push_back(e);
    #1;
  endtask : op

  task automatic drain();
    int n = 0;
    vld = 1'b0;
    while ((exp_q.size() != 0 || rdy !== 1'b1) && n < 500) begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask : drain

  always @(posedge clk) begin
    if (done === 1'b1) begin
      e_m = exp_q.size() != 0 ? exp_q.pop_front() : 34'h3FFFFFFFF;
      check("fault", {31'h0, fault}, {31'h0, e_m[32]});
      if (e_m[33] !== 1'b1) check("read data", rdata, e_m[31:0]);
      check("autovector", {31'h0, auto_vector_ack}, {31'h0, av_en && (&k)});
    end
  end

  // full run is a few hundred cycles
  initial begin
    #2000000;
    num_errors++;
    close_out();
  end

  initial begin
    logic [31:0] r, q;
    int n;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int p = 1; p >= 0; p--) begin
      wide = p[0];
      r = xs();
      q = xs();
      op(1'b1, 2'h0, 24'h000010, r, 34'h0);
      op(1'b0, 2'h0, 24'h000010, 32'h0, {2'h0, r});
      op(1'b1, 2'h2, 24'h000022, q, 34'h0);
      op(1'b1, 2'h1, 24'h000033, q, 34'h0);
      op(1'b0, 2'h2, 24'h000022, 32'h0, {18'h0, q[15:0]});
      op(1'b0, 2'h1, 24'h000033, 32'h0, {26'h0, q[7:0]});
      op(1'b0, 2'h1, 24'h000012, 32'h0, {26'h0, r[15:8]});
      drain();
    end
    mode = 2'h1;
    mon_en = 1'b1;
    for (int s = 0; s < 4; s++) begin
      mon_sel = s[1:0];
      op(1'b1, 2'h2, 24'h000040, 32'h0, {2'h3, 32'h0});
      vld = 1'b0;
      for (n = 0; done !== 1'b1 && n < 200; n++) begin
        @(posedge clk);
      end
      check("timeout span", {31'h0, n >= (64 >> s) && n <= (64 >> s) + 8}, 32'h1);
      drain();
    end
    av_en = 1'b1;
    k = 3'h6;
    op(1'b0, 2'h2, 24'h000050, 32'h0, {2'h2, 32'h0});
    drain();
    mode = 2'h2;
    mon_en = 1'b0;
    op(1'b0, 2'h2, 24'h000022, 32'h0, {2'h3, 32'h0});
    drain();
    mode = 2'h1;
    cs_en = 1'b1;
    op(1'b0, 2'h2, 24'h000022, 32'h0, {18'h0, q[15:0]});
    drain();
    close_out();
  end
endmodule : test_async_external_bus_master
